/* inc/mfm_pkg.sv */
package mfm_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_CFG = 5'h04;
    localparam logic [4:0] OFS_PERR = 5'h08;
    localparam logic [4:0] OFS_FORCE = 5'h0C;
    localparam logic [4:0] OFS_STATUS = 5'h10;

    // fault counts and indices into the fault vector
    localparam int SAF_N = 4;
    localparam int FLT_N = 10;
    localparam int F_PLIM = 0;
    localparam int F_NLIM = 1;
    localparam int F_PERR = 2;
    localparam int F_SSTOP = 3;
    localparam int F_FBK = 4;
    localparam int F_OCUR = 5;
    localparam int F_OTEMP = 6;
    localparam int F_OVOLT = 7;
    localparam int F_UVOLT = 8;
    localparam int F_IMAGE = 9;

    // field positions
    localparam int CTRL_CLR_BIT = 0;
    localparam int CFG_EN_LSB = 0;
    localparam int CFG_DIS_LSB = 4;
    localparam int CFG_ENC_BIT = 8;
    localparam int CFG_SSTOP_BIT = 9;
    localparam int STS_FLT_LSB = 0;
    localparam int STS_DIS_BIT = 16;
    localparam int STS_FWD_BIT = 17;
    localparam int STS_REV_BIT = 18;
    localparam int STS_HOLD_BIT = 19;
    localparam int STS_EN_BIT = 20;

    // reset values and the full-scale force setting
    localparam logic [31:0] CFG_RST = 32'h0000_000F;
    localparam logic [31:0] PERR_RST = 32'h0000_0100;
    localparam logic [6:0] FORCE_RST = 7'h64;
    localparam logic [6:0] FORCE_FULL = 7'h64;

    // thresholds
    localparam logic [7:0] TEMP_MAX_C = 8'h4B;
    localparam logic [9:0] SUPPLY_MAX_RST = 10'h1A4;
    localparam logic [9:0] SUPPLY_MIN_RST = 10'h0B4;

    // red led blink half period
    localparam int CLK_MHZ = 200;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;
endpackage : mfm_pkg

/* logic/mfm_fault_cell.sv */
`timescale 1ns/1ps
// one fault flag: set by its condition, cleared either on its own
// clear condition or only on the latched clear event
module mfm_fault_cell (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic en,
    input wire logic latch_sel,
    input wire logic cond,
    input wire logic auto_clr,
    input wire logic latch_clr,
    output logic flag
);
    logic flag_ff; // fault state
    logic nxt_flag; // next fault state
    logic clr_now; // clear selected by reaction type

    // latch-type flags ignore the automatic clear
    assign clr_now = latch_sel ? latch_clr : auto_clr;
    // a present condition always wins over any clear
    assign nxt_flag = !en ? 1'b0 : (cond ? 1'b1 : (clr_now ? 1'b0 : flag_ff));
    assign flag = flag_ff;

    // flag register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end
endmodule : mfm_fault_cell

/* logic/mfm_fault_mgr.sv */
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - faults split into safety and critical classes
// - stop-motion safety faults self-clear when condition gone
// - disable-type safety faults latch until clear sequence
// - critical faults disable motor immediately, always
// - latched clear needs condition absent, enable low-high
// - host software clear acts like enable toggle
// - positive limit blocks forward, allows reverse
// - positive limit clears when inactive and moved negative
// - negative limit mirrors positive limit behaviour
// - position error needs encoder; trips beyond limit
// - stop-motion position error clears on next move
// - force below full suppresses error, holds position
// - assigned software stop trips while input high
// - software stop clears on low, blocks motion
// - over-temperature above maximum is critical
// - over- and under-voltage are separate critical faults
// - checksum or firmware mismatch is critical
// - output short to ground is critical overcurrent
// - feedback device malfunction is critical
// - green powered, red solid critical, blinking safety; here green lights only while enabled and motor not disabled
// - ignore start pulses when disabled or stopped
module mfm_fault_mgr #(
    parameter int BLINK_CYC = mfm_pkg::BLINK_CYC,
    parameter logic [9:0] SUPPLY_MAX = mfm_pkg::SUPPLY_MAX_RST,
    parameter logic [9:0] SUPPLY_MIN = mfm_pkg::SUPPLY_MIN_RST
) (
    input wire logic mclk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // controller inputs
    input wire logic enable_in,
    input wire logic lim_pos_in,
    input wire logic lim_neg_in,
    input wire logic sstop_in,
    input wire logic start_in,
    input wire logic step_pos_in,
    input wire logic step_neg_in,
    // position feedback
    input wire logic signed [31:0] enc_pos,
    input wire logic signed [31:0] cmd_pos,
    // critical condition reports
    input wire logic fbk_bad_in,
    input wire logic short_in,
    input wire logic [7:0] temp_c,
    input wire logic [9:0] supply_lvl,
    input wire logic nvm_csum_bad_in,
    input wire logic fw_mismatch_in,
    // outputs
    output logic motor_dis,
    output logic fwd_ok,
    output logic rev_ok,
    output logic hold_pos,
    output logic start_ok,
    output logic led_green,
    output logic led_red
);
    localparam int BW = $clog2(BLINK_CYC + 1); // blink counter width

    // register state
    logic [31:0] cfg_ff; // enables, reactions, encoder, stop input
    logic [31:0] perr_ff; // position error limit
    logic [6:0] force_ff; // force setting in percent
    logic sw_clr_ff; // one-cycle host clear pulse
    logic wait_ff; // waitrequest, high when idle
    logic [31:0] rdata_ff; // read data register

    // enable synchroniser and edge detect
    logic en_s1_ff; // first stage, read only by second
    logic en_s2_ff; // synchronised enable
    logic en_prev_ff; // previous synchronised sample

    // output registers
    logic dis_ff;
    logic fwd_ff;
    logic rev_ff;
    logic hold_ff;
    logic start_ff;
    logic green_ff;
    logic red_ff;
    logic blink_ff; // blink phase
    logic [BW-1:0] blink_cnt_ff; // blink divider

    // decode and fault wires
    logic req; // any bus request
    logic take; // request completes this edge
    logic [31:0] rd_mux; // selected read value
    logic [31:0] sts_word; // status register view
    logic en_rise; // synchronised enable rising edge
    logic latch_clr; // clear event for latched faults
    logic enc_on; // encoder fitted
    logic sstop_on; // an input assigned to software stop
    logic sstop_lvl; // software stop input level
    logic push_mode; // force below full scale
    logic signed [32:0] pos_diff; // encoder minus commanded
    logic [32:0] pos_mag; // magnitude of the difference
    logic perr_raw; // difference beyond limit
    logic move_acc; // start pulse accepted
    logic [mfm_pkg::FLT_N-1:0] f_cond; // fault conditions
    logic [mfm_pkg::FLT_N-1:0] f_auto; // automatic clears
    logic [mfm_pkg::FLT_N-1:0] f_en; // fault enables
    logic [mfm_pkg::FLT_N-1:0] f_sel; // latch selects
    logic [mfm_pkg::FLT_N-1:0] f_flag; // fault flags
    logic saf_any; // any safety fault active
    logic crit_any; // any critical fault active
    logic nxt_dis;
    logic nxt_fwd;
    logic nxt_rev;
    logic blink_tick; // end of a half period

    // byte-lane merge for writes
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // bus decode: one wait cycle, then the request is taken
    assign req = avs_read | avs_write;
    assign take = req & ~wait_ff;

    // status view of the block's own state
    assign sts_word = {11'h000, en_s2_ff, hold_ff, rev_ff, fwd_ff, dis_ff,
                       6'h00, f_flag};

    // read multiplexer; unmapped offsets read as zero
    assign rd_mux =
        (avs_address == mfm_pkg::OFS_CFG) ? cfg_ff :
        (avs_address == mfm_pkg::OFS_PERR) ? perr_ff :
        (avs_address == mfm_pkg::OFS_FORCE) ? {25'h000_0000, force_ff} :
        (avs_address == mfm_pkg::OFS_STATUS) ? sts_word :
        32'h0000_0000;

    // waitrequest drops for exactly one cycle per request
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= ~(req & wait_ff);
        end
    end

    // read data is loaded while waitrequest is still high
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read & wait_ff) begin
            rdata_ff <= rd_mux;
        end
    end

    // configuration writes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cfg_ff <= mfm_pkg::CFG_RST;
            perr_ff <= mfm_pkg::PERR_RST;
            force_ff <= mfm_pkg::FORCE_RST;
        end else if (take & avs_write) begin
            if (avs_address == mfm_pkg::OFS_CFG) begin
                cfg_ff <= be_merge(cfg_ff, avs_writedata, avs_byteenable);
            end
            if (avs_address == mfm_pkg::OFS_PERR) begin
                perr_ff <= be_merge(perr_ff, avs_writedata, avs_byteenable);
            end
            if (avs_address == mfm_pkg::OFS_FORCE && avs_byteenable[0]) begin
                force_ff <= avs_writedata[6:0];
            end
        end
    end

    // host clear: writing one to the clear bit gives one pulse
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sw_clr_ff <= 1'b0;
        end else begin
            sw_clr_ff <= take & avs_write & avs_byteenable[0] &
                         (avs_address == mfm_pkg::OFS_CTRL) &
                         avs_writedata[mfm_pkg::CTRL_CLR_BIT];
        end
    end

    // enable synchroniser; first stage feeds only the second
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            // all three agree, so release cannot fake a rise and clear
            en_s1_ff <= 1'b1;
            en_s2_ff <= 1'b1;
            en_prev_ff <= 1'b1; // no false edge right after reset
        end else begin
            en_s1_ff <= enable_in;
            en_s2_ff <= en_s1_ff;
            en_prev_ff <= en_s2_ff;
        end
    end

    // low sample then high sample, so one toggle clears once
    assign en_rise = en_s2_ff & ~en_prev_ff;
    assign latch_clr = en_rise | sw_clr_ff;

    // configuration fields
    assign enc_on = cfg_ff[mfm_pkg::CFG_ENC_BIT];
    assign sstop_on = cfg_ff[mfm_pkg::CFG_SSTOP_BIT];
    assign sstop_lvl = sstop_on & sstop_in;
    assign push_mode = force_ff < mfm_pkg::FORCE_FULL;

    // position error magnitude against the limit
    assign pos_diff = 33'(enc_pos) - 33'(cmd_pos);
    assign pos_mag = pos_diff[32] ? 33'(-pos_diff) : 33'(pos_diff);
    assign perr_raw = pos_mag > {1'b0, perr_ff};

    // a start pulse counts only when motion may begin
    assign move_acc = start_in & en_s2_ff & ~sstop_lvl & ~nxt_dis;

    // safety fault conditions and their automatic clears
    assign f_cond[mfm_pkg::F_PLIM] = lim_pos_in;
    assign f_auto[mfm_pkg::F_PLIM] = ~lim_pos_in & step_neg_in;
    assign f_cond[mfm_pkg::F_NLIM] = lim_neg_in;
    assign f_auto[mfm_pkg::F_NLIM] = ~lim_neg_in & step_pos_in;
    // push mode suppresses the error and holds instead
    assign f_cond[mfm_pkg::F_PERR] = perr_raw & ~push_mode;
    assign f_auto[mfm_pkg::F_PERR] = move_acc;
    assign f_cond[mfm_pkg::F_SSTOP] = sstop_in;
    assign f_auto[mfm_pkg::F_SSTOP] = ~sstop_in;

    // critical fault conditions; they never clear on their own
    assign f_cond[mfm_pkg::F_FBK] = fbk_bad_in;
    assign f_cond[mfm_pkg::F_OCUR] = short_in;
    assign f_cond[mfm_pkg::F_OTEMP] = temp_c > mfm_pkg::TEMP_MAX_C;
    assign f_cond[mfm_pkg::F_OVOLT] = supply_lvl > SUPPLY_MAX;
    assign f_cond[mfm_pkg::F_UVOLT] = supply_lvl < SUPPLY_MIN;
    assign f_cond[mfm_pkg::F_IMAGE] = nvm_csum_bad_in | fw_mismatch_in;
    assign f_auto[mfm_pkg::FLT_N-1:mfm_pkg::SAF_N] = '0;

    // per-fault enable and reaction; critical ones forced on
    assign f_en[mfm_pkg::F_PLIM] = cfg_ff[mfm_pkg::CFG_EN_LSB];
    assign f_en[mfm_pkg::F_NLIM] = cfg_ff[mfm_pkg::CFG_EN_LSB + 1];
    // position error may only run with an encoder fitted
    assign f_en[mfm_pkg::F_PERR] = cfg_ff[mfm_pkg::CFG_EN_LSB + 2] &
                                   enc_on;
    assign f_en[mfm_pkg::F_SSTOP] = cfg_ff[mfm_pkg::CFG_EN_LSB + 3] &
                                    sstop_on;
    // software stop always behaves as stop-motion
    assign f_sel[mfm_pkg::SAF_N-1:0] =
        {1'b0, cfg_ff[mfm_pkg::CFG_DIS_LSB +: mfm_pkg::SAF_N-1]};
    assign f_en[mfm_pkg::FLT_N-1:mfm_pkg::SAF_N] = '1;
    assign f_sel[mfm_pkg::FLT_N-1:mfm_pkg::SAF_N] = '1;

    // one flag cell per fault, safety then critical
    for (genvar g = 0; g < mfm_pkg::FLT_N; g++) begin : g_flt
        mfm_fault_cell u_cell (
            .mclk(mclk),
            .resetn(resetn),
            .en(f_en[g]),
            .latch_sel(f_sel[g]),
            .cond(f_cond[g]),
            .auto_clr(f_auto[g]),
            .latch_clr(latch_clr),
            .flag(f_flag[g])
        );
    end

    // class summaries
    assign saf_any = |f_flag[mfm_pkg::SAF_N-1:0];
    assign crit_any = |f_flag[mfm_pkg::FLT_N-1:mfm_pkg::SAF_N];

    // disable is critical flags plus latch-type safety flags;
    // critical conditions are or-ed in so disable lands on the same edge
    assign nxt_dis = crit_any |
        (|f_cond[mfm_pkg::FLT_N-1:mfm_pkg::SAF_N]) |
        (|(f_flag[mfm_pkg::SAF_N-1:0] &
           f_sel[mfm_pkg::SAF_N-1:0]));

    // direction permits; software stop blocks both ways
    assign nxt_fwd = ~nxt_dis & en_s2_ff & ~f_flag[mfm_pkg::F_SSTOP] &
                     ~f_flag[mfm_pkg::F_PLIM];
    assign nxt_rev = ~nxt_dis & en_s2_ff & ~f_flag[mfm_pkg::F_SSTOP] &
                     ~f_flag[mfm_pkg::F_NLIM];

    // motion control outputs
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dis_ff <= 1'b1;
            fwd_ff <= 1'b0;
            rev_ff <= 1'b0;
            hold_ff <= 1'b0;
            start_ff <= 1'b0;
        end else begin
            dis_ff <= nxt_dis;
            fwd_ff <= nxt_fwd;
            rev_ff <= nxt_rev;
            hold_ff <= perr_raw & push_mode & f_en[mfm_pkg::F_PERR];
            start_ff <= move_acc;
        end
    end

    // blink divider; a slower rate as an enable pulse
    assign blink_tick = blink_cnt_ff == BW'(BLINK_CYC - 1);
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            blink_cnt_ff <= '0;
            blink_ff <= 1'b0;
        end else if (blink_tick) begin
            blink_cnt_ff <= '0;
            blink_ff <= ~blink_ff;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + 1'b1;
        end
    end

    // leds: critical solid wins over blinking safety
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            green_ff <= 1'b0;
            red_ff <= 1'b0;
        end else begin
            green_ff <= ~nxt_dis & en_s2_ff;
            red_ff <= crit_any | (saf_any & blink_ff);
        end
    end

    // outputs straight from flip-flops
    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign motor_dis = dis_ff;
    assign fwd_ok = fwd_ff;
    assign rev_ok = rev_ff;
    assign hold_pos = hold_ff;
    assign start_ok = start_ff;
    assign led_green = green_ff;
    assign led_red = red_ff;
endmodule : mfm_fault_mgr

/* tb/mfm_fault_mgr_sva.sv */
`timescale 1ns/1ps
// fault outputs checked against their causes at the pins
module mfm_fault_mgr_sva #(
    parameter logic [9:0] SUPPLY_MAX = 10'h1A4,
    parameter logic [9:0] SUPPLY_MIN = 10'h0B4
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic enable_in,
    input wire logic fbk_bad_in,
    input wire logic short_in,
    input wire logic [7:0] temp_c,
    input wire logic [9:0] supply_lvl,
    input wire logic nvm_csum_bad_in,
    input wire logic fw_mismatch_in,
    input wire logic motor_dis,
    input wire logic start_ok,
    input wire logic led_red
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // quiet stretch: no clear source can be pending
    sequence s_quiet;
        (enable_in && !avs_write)[*6];
    endsequence
    sequence s_trip;
        s_quiet ##0 short_in ##1 (enable_in && !avs_write)[*8];
    endsequence
    AST_OCUR: assert property (short_in |=> motor_dis)
        else $error("short did not disable motor");
    AST_FBK: assert property (fbk_bad_in |=> motor_dis)
        else $error("feedback fault did not disable motor");
    AST_OTEMP: assert property (temp_c > 8'h4B |=> motor_dis)
        else $error("over temperature did not disable motor");
    AST_SUPPLY: assert property ((supply_lvl > SUPPLY_MAX) ||
        (supply_lvl < SUPPLY_MIN) |=> motor_dis)
        else $error("supply fault did not disable motor");
    AST_IMAGE: assert property (nvm_csum_bad_in || fw_mismatch_in |=>
        motor_dis) else $error("image fault did not disable motor");
    AST_LATCH: assert property (s_trip |-> motor_dis)
        else $error("critical fault released without clear");
    AST_RED: assert property (short_in |-> ##[1:2] led_red)
        else $error("red lamp off on critical fault");
    AST_START: assert property ((!enable_in)[*4] |-> !start_ok)
        else $error("start accepted while disabled");
    AST_WAIT: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered");
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
endmodule : mfm_fault_mgr_sva
bind mfm_fault_mgr mfm_fault_mgr_sva #(.SUPPLY_MAX(SUPPLY_MAX),
    .SUPPLY_MIN(SUPPLY_MIN)) mfm_fault_mgr_sva_i (.mclk(mclk),
    .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .enable_in(enable_in),
    .fbk_bad_in(fbk_bad_in), .short_in(short_in), .temp_c(temp_c),
    .supply_lvl(supply_lvl), .nvm_csum_bad_in(nvm_csum_bad_in),
    .fw_mismatch_in(fw_mismatch_in), .motor_dis(motor_dis),
    .start_ok(start_ok), .led_red(led_red));

/* tb/mfm_fault_mgr_test.sv */
`timescale 1ns/1ps
// self-checking bench for the fault manager
module mfm_fault_mgr_test;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, enable_in, lim_pos_in, lim_neg_in, sstop_in;
    logic start_in, step_pos_in, step_neg_in;
    logic signed [31:0] enc_pos = 32'sh0000_0000;
    logic signed [31:0] cmd_pos = 32'sh0000_0000;
    logic fbk_bad_in = 1'b0, short_in = 1'b0, nvm_csum_bad_in = 1'b0;
    logic fw_mismatch_in = 1'b0;
    logic [7:0] temp_c = 8'h4B; // at the limit, not above it
    logic [9:0] supply_lvl = 10'h100;
    logic motor_dis, fwd_ok, rev_ok, hold_pos, start_ok, led_green, led_red;
    int err_total = 0;
    int n_tests = 0;
    int n_start = 0; // accepted start cycles
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (start_ok === 1'b1) n_start++;
    mfm_plc_model plc_i (.mclk(mclk), .enable_in(enable_in),
        .lim_pos_in(lim_pos_in), .lim_neg_in(lim_neg_in),
        .sstop_in(sstop_in), .start_in(start_in),
        .step_pos_in(step_pos_in), .step_neg_in(step_neg_in));
    // short blink period keeps the run brief
    mfm_fault_mgr #(.BLINK_CYC(4)) mfm_fault_mgr_i (.mclk(mclk),
        .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .enable_in(enable_in),
        .lim_pos_in(lim_pos_in), .lim_neg_in(lim_neg_in),
        .sstop_in(sstop_in), .start_in(start_in),
        .step_pos_in(step_pos_in), .step_neg_in(step_neg_in),
        .enc_pos(enc_pos), .cmd_pos(cmd_pos), .fbk_bad_in(fbk_bad_in),
        .short_in(short_in), .temp_c(temp_c), .supply_lvl(supply_lvl),
        .nvm_csum_bad_in(nvm_csum_bad_in), .fw_mismatch_in(fw_mismatch_in),
        .motor_dis(motor_dis), .fwd_ok(fwd_ok), .rev_ok(rev_ok),
        .hold_pos(hold_pos), .start_ok(start_ok), .led_green(led_green),
        .led_red(led_red));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one avalon access; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge mclk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) begin
            err_total++;
            report_and_stop();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        bus(1'b0, mfm_pkg::OFS_STATUS, 32'h0000_0000);
    endtask : wt
    task automatic t_regs();
        bus(1'b0, mfm_pkg::OFS_CFG, 32'h0000_0000);
        chk("cfg", rd, mfm_pkg::CFG_RST);
        bus(1'b0, mfm_pkg::OFS_PERR, 32'h0000_0000);
        chk("perr", rd, mfm_pkg::PERR_RST);
        bus(1'b0, mfm_pkg::OFS_FORCE, 32'h0000_0000);
        chk("force", rd, {25'h0, mfm_pkg::FORCE_RST});
        bus(1'b0, 5'h14, 32'h0000_0000);
        chk("unmapped", rd, 32'h0000_0000);
        bus(1'b1, mfm_pkg::OFS_STATUS, 32'hFFFF_FFFF);
        wt(1);
        chk("status", {rd[16], rd[9:0]}, 32'h0000_0000);
        $display("regs done");
    endtask : t_regs
    // drive one critical source: 0 fbk..4 uvolt, 5 csum, 6 firmware
    task automatic crit_set(input int i, input logic v);
        @(posedge mclk);
        fbk_bad_in <= v && i == 0;
        short_in <= v && i == 1;
        temp_c <= (v && i == 2) ? 8'h4C : 8'h4B;
        supply_lvl <= (v && i == 3) ? 10'h1A5 :
            (v && i == 4) ? 10'h0B3 : 10'h100;
        nvm_csum_bad_in <= v && i == 5;
        fw_mismatch_in <= v && i == 6;
    endtask : crit_set
    task automatic t_crit();
        logic [31:0] ex;
        for (int i = 0; i < 7; i++) begin
            crit_set(i, 1'b1);
            wt(3);
            chk("crit_dis", motor_dis, 1);
            chk("red", led_red, 1);
            crit_set(i, 1'b0);
            wt(6);
            ex = 32'h0000_0001 << (i < 6 ? 4 + i : 9);
            chk("crit_flag", rd[9:0], ex);
            plc_i.toggle_en();
            wt(8);
            chk("crit_clr", {rd[16], rd[9:0], motor_dis}, 0);
            chk("green", led_green, 1);
        end
        $display("critical done");
    endtask : t_crit
    task automatic t_limit();
        int n;
        for (int d = 0; d < 2; d++) begin
            plc_i.set_lvl(d == 0, d == 1, 1'b0);
            wt(4);
            chk("fwd", fwd_ok, d == 1);
            chk("rev", rev_ok, d == 0);
            // any eight cycles of a blinking lamp hold four lit ones
            n = 0;
            repeat (8) begin
                @(posedge mclk);
                n += led_red;
            end
            chk("blink", n, 4);
            plc_i.set_lvl(1'b0, 1'b0, 1'b0);
            plc_i.pulse(1 + d);
            wt(4);
            chk("lim_hold", rd[1:0], 2'b01 << d);
            chk("lim_dis", motor_dis, 0);
            plc_i.pulse(2 - d);
            wt(4);
            chk("lim_clr", rd[1:0], 0);
        end
        $display("limits done");
    endtask : t_limit
    task automatic t_latch();
        bus(1'b1, mfm_pkg::OFS_CFG, 32'h0000_001F);
        plc_i.set_lvl(1'b1, 1'b0, 1'b0);
        wt(3);
        chk("lat_dis", motor_dis, 1);
        plc_i.set_lvl(1'b0, 1'b0, 1'b0);
        plc_i.pulse(2);
        wt(4);
        chk("lat_hold", {rd[0], motor_dis}, 2'b11);
        bus(1'b1, mfm_pkg::OFS_CTRL, 32'h0000_0001);
        wt(4);
        chk("host_clr", {rd[0], motor_dis}, 0);
        bus(1'b1, mfm_pkg::OFS_CFG, 32'h0000_020F);
        plc_i.set_lvl(1'b0, 1'b0, 1'b1);
        wt(4);
        chk("sstop", {rd[3], fwd_ok, rev_ok, motor_dis}, 4'h8);
        plc_i.pulse(0);
        wt(16);
        chk("no_start", n_start, 0);
        plc_i.set_lvl(1'b0, 1'b0, 1'b0);
        wt(4);
        chk("sstop_clr", rd[3], 0);
        $display("latch and stop done");
    endtask : t_latch
    task automatic t_perr();
        enc_pos <= 32'sh0000_0101;
        wt(4);
        chk("no_enc", rd[2], 0);
        bus(1'b1, mfm_pkg::OFS_CFG, 32'h0000_010F);
        wt(3);
        chk("perr_set", rd[2], 1);
        enc_pos <= 32'sh0000_0100;
        wt(4);
        chk("perr_hold", rd[2], 1);
        plc_i.pulse(0);
        wt(4);
        chk("perr_clr", {rd[2], 31'(n_start)}, 1);
        bus(1'b1, mfm_pkg::OFS_FORCE, 32'h0000_0032);
        enc_pos <= 32'sh0000_0101;
        wt(4);
        chk("push", {rd[2], hold_pos}, 1);
        $display("position error done");
    endtask : t_perr
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        t_regs();
        t_crit();
        t_limit();
        t_latch();
        t_perr();
        report_and_stop();
    end
endmodule : mfm_fault_mgr_test

/* tb/mfm_plc_model.sv */
`timescale 1ns/1ps
// controller stand-in: enable, limits, stop, start and step lines
module mfm_plc_model (
    output logic enable_in,
    output logic lim_pos_in,
    output logic lim_neg_in,
    output logic sstop_in,
    output logic start_in,
    output logic step_pos_in,
    output logic step_neg_in,
    input wire logic mclk
);
    initial begin
        enable_in = 1'b1;
        {lim_pos_in, lim_neg_in, sstop_in} = 3'h0;
        {start_in, step_pos_in, step_neg_in} = 3'h0;
    end
    // levels change just after an edge, never mid-cycle
    task automatic set_lvl(input logic pl, input logic nl, input logic ss);
        @(posedge mclk);
        lim_pos_in <= pl;
        lim_neg_in <= nl;
        sstop_in <= ss;
    endtask : set_lvl
    // low long enough for the two-flop sync to see it
    task automatic toggle_en();
        @(posedge mclk);
        enable_in <= 1'b0;
        repeat (4) @(posedge mclk);
        enable_in <= 1'b1;
    endtask : toggle_en
    // one-cycle pulse: 0 start, 1 step forward, 2 step reverse
    task automatic pulse(input int sel);
        @(posedge mclk);
        start_in <= (sel == 0);
        step_pos_in <= (sel == 1);
        step_neg_in <= (sel == 2);
        @(posedge mclk);
        {start_in, step_pos_in, step_neg_in} <= 3'h0;
    endtask : pulse
endmodule : mfm_plc_model
